// ==== core/cxr_consts.vh ====
// Constants for the transceiver control and status register pair
`ifndef CXR_CONSTS_VH
`define CXR_CONSTS_VH

// ***********************************
// Register map
// ***********************************
`define CXR_ADDR_W 7
`define CXR_CTRL_ADDR 7'h20
`define CXR_STAT_ADDR 7'h22
`define CXR_PN_CFG_LO 7'h26
`define CXR_PN_CFG_HI 7'h6f

// ***********************************
// Control fields
// ***********************************
`define CXR_CTRL_FD 6
`define CXR_CTRL_PNOK 5
`define CXR_CTRL_SWK 4
`define CXR_CTRL_MASK 8'h73
`define CXR_CTRL_RST 8'h00

// ***********************************
// Mode codes
// ***********************************
`define CXR_MODE_OFF 2'h0
`define CXR_MODE_ACT_UV 2'h1
`define CXR_MODE_ACT_NUV 2'h2
`define CXR_MODE_LISTEN 2'h3

// ***********************************
// Transceiver states
// ***********************************
`define CXR_ST_OFFLINE 2'h0
`define CXR_ST_ACTIVE 2'h1
`define CXR_ST_LISTEN 2'h2
`define CXR_ST_CANOFF 2'h3

`endif

// ==== core/cxr_mode_fsm.v ====
// Transceiver operating mode state machine
`timescale 1ns/1ps
`default_nettype none
`include "cxr_consts.vh"
module cxr_mode_fsm (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Control
	input wire [1:0] mode_sel_i,
	input wire normal_mode_i,
	input wire txd_low_i,
	input wire supply_low_i,
	input wire bat_low_i,
	// State
	output reg [1:0] state_o
);
	// Codes shared with the register block, which decodes active and listen-only
	localparam [1:0] ST_OFFLINE = `CXR_ST_OFFLINE;
	localparam [1:0] ST_ACTIVE = `CXR_ST_ACTIVE;
	localparam [1:0] ST_LISTEN = `CXR_ST_LISTEN;
	localparam [1:0] ST_CANOFF = `CXR_ST_CANOFF;

	reg [1:0] state_nxt;

	always @* begin
		state_nxt = ST_OFFLINE;
		if (bat_low_i) begin
			state_nxt = ST_CANOFF;
		end else if (!normal_mode_i) begin
			state_nxt = ST_OFFLINE;
		end else begin
			case (mode_sel_i)
				`CXR_MODE_OFF: state_nxt = ST_OFFLINE;
				`CXR_MODE_ACT_UV: begin
					if (supply_low_i)
						state_nxt = ST_OFFLINE;
					else if (txd_low_i && state_o != ST_ACTIVE)
						state_nxt = ST_LISTEN;
					else
						state_nxt = ST_ACTIVE;
				end
				`CXR_MODE_ACT_NUV: begin
					if (txd_low_i && state_o != ST_ACTIVE)
						state_nxt = ST_LISTEN;
					else
						state_nxt = ST_ACTIVE;
				end
				`CXR_MODE_LISTEN: state_nxt = ST_LISTEN;
				default: state_nxt = ST_OFFLINE;
			endcase
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			state_o <= ST_OFFLINE;
		else
			state_o <= state_nxt;
	end
endmodule // cxr_mode_fsm
`default_nettype wire

// ==== core/cxr_regs.v ====
// Control and status register pair of the CAN transceiver
`timescale 1ns/1ps
`default_nettype none
`include "cxr_consts.vh"
module cxr_regs (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Register access from the serial interface (same clock)
	input wire [`CXR_ADDR_W-1:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	// Device state, asynchronous
	input wire normal_mode_i,
	input wire txd_i,
	input wire supply_low_i,
	input wire bat_low_i,
	input wire osc_locked_i,
	input wire bus_silent_i,
	input wire tx_timeout_i,
	input wire frame_detect_error_i,
	// Transceiver control
	output reg fd_tolerance_enable_o,
	output reg selective_wake_enable_o,
	output reg pn_config_valid_o,
	output reg tx_enable_o,
	output reg rx_enable_o,
	output reg bias_enable_o,
	output reg active_mode_o
);
	// ***********************************
	// Input synchronisation
	// ***********************************
	wire [7:0] async_in;
	wire [7:0] sync_in;
	assign async_in = {normal_mode_i, ~txd_i, supply_low_i, bat_low_i,
		osc_locked_i, bus_silent_i, tx_timeout_i, frame_detect_error_i};

	cxr_sync2 #(.W(8)) u_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.d_i(async_in),
		.q_o(sync_in)
	);

	wire s_normal;
	wire s_txd_low;
	wire s_supply_low;
	wire s_bat_low;
	wire s_osc;
	wire s_silent;
	wire s_tx_to;
	wire s_fde;
	assign s_normal = sync_in[7];
	assign s_txd_low = sync_in[6];
	assign s_supply_low = sync_in[5];
	assign s_bat_low = sync_in[4];
	assign s_osc = sync_in[3];
	assign s_silent = sync_in[2];
	assign s_tx_to = sync_in[1];
	assign s_fde = sync_in[0];

	// ***********************************
	// Address decoding
	// ***********************************
	// Only the range of the configuration block matters; its contents live elsewhere
	function is_pn_cfg;
		input [`CXR_ADDR_W-1:0] a;
		begin
			is_pn_cfg = (a >= `CXR_PN_CFG_LO) && (a <= `CXR_PN_CFG_HI);
		end
	endfunction

	function addr_hit;
		input [`CXR_ADDR_W-1:0] a;
		input [`CXR_ADDR_W-1:0] target;
		begin
			addr_hit = (a == target);
		end
	endfunction

	wire sel_ctrl;
	wire sel_stat;
	assign sel_ctrl = addr_hit(reg_addr_i, `CXR_CTRL_ADDR);
	assign sel_stat = addr_hit(reg_addr_i, `CXR_STAT_ADDR);

	// ***********************************
	// Write decoding
	// ***********************************
	wire wr_ctrl;
	wire wr_pn_cfg;
	// Writes to the status address fall through and are dropped
	assign wr_ctrl = reg_wr_i && sel_ctrl;
	assign wr_pn_cfg = reg_wr_i && is_pn_cfg(reg_addr_i);

	// ***********************************
	// Control register
	// ***********************************
	reg [7:0] ctrl_r;
	reg [7:0] ctrl_nxt;

	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			// Mask keeps reserved bits at zero whatever is written
			ctrl_nxt = reg_wdata_i & `CXR_CTRL_MASK;
		end
		if (wr_pn_cfg) begin
			ctrl_nxt[`CXR_CTRL_PNOK] = 1'b0;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= `CXR_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ***********************************
	// Control fields
	// ***********************************
	wire fd_tolerance_enable;
	wire pn_config_valid;
	wire selective_wake_enable;
	wire [1:0] transceiver_mode_select;
	assign fd_tolerance_enable = ctrl_r[`CXR_CTRL_FD];
	assign pn_config_valid = ctrl_r[`CXR_CTRL_PNOK];
	assign selective_wake_enable = ctrl_r[`CXR_CTRL_SWK];
	assign transceiver_mode_select = ctrl_r[1:0];

	// ***********************************
	// Operating mode
	// ***********************************
	wire [1:0] xcvr_state;
	// Mode changes take effect one cycle after the control write lands
	cxr_mode_fsm u_fsm (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.mode_sel_i(transceiver_mode_select),
		.normal_mode_i(s_normal),
		.txd_low_i(s_txd_low),
		.supply_low_i(s_supply_low),
		.bat_low_i(s_bat_low),
		.state_o(xcvr_state)
	);

	// ***********************************
	// Derived state
	// ***********************************
	wire is_active;
	wire is_listen;
	wire rx_path_on;
	wire tx_allowed;
	assign is_active = (xcvr_state == `CXR_ST_ACTIVE);
	assign is_listen = (xcvr_state == `CXR_ST_LISTEN);
	// Receiver and bias serve both listening and active operation
	assign rx_path_on = is_active | is_listen;
	// Transmitter stays off on time-out to protect the bus
	assign tx_allowed = is_active && !s_tx_to;

	// ***********************************
	// Status bits
	// ***********************************
	wire pn_error_flag;
	wire pn_config_status;
	wire pn_osc_locked;
	wire bus_silence_flag;
	wire supply_low_flag;
	wire tx_timeout_flag;
	// Unconfirmed configuration counts as an error; wake-up falls back to the pattern
	assign pn_error_flag = s_fde | ~pn_config_valid;
	assign pn_config_status = pn_config_valid;
	assign pn_osc_locked = s_osc;
	assign bus_silence_flag = s_silent;
	// Supply indication only meaningful with detection enabled
	assign supply_low_flag = s_supply_low &&
		(transceiver_mode_select == `CXR_MODE_ACT_UV);
	assign tx_timeout_flag = s_tx_to;

	// ***********************************
	// Status assembly
	// ***********************************
	wire [7:0] status;
	assign status = {
		is_active,
		pn_error_flag,
		pn_config_status,
		pn_osc_locked,
		bus_silence_flag,
		1'b0,
		supply_low_flag,
		tx_timeout_flag
	};

	// ***********************************
	// Read data
	// ***********************************
	reg [7:0] rdata_nxt;

	always @* begin
		case ({sel_stat, sel_ctrl})
			2'h1: begin
				rdata_nxt = ctrl_r;
			end
			2'h2: begin
				rdata_nxt = status;
			end
			default: begin
				// Unmapped addresses read as zero
				rdata_nxt = 8'h00;
			end
		endcase
	end

	// Registered so the host sees a settled byte one cycle after the address
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// ***********************************
	// Transceiver control outputs
	// ***********************************
	reg fd_out_nxt;
	reg swk_out_nxt;
	reg pnok_out_nxt;
	reg tx_out_nxt;
	reg rx_out_nxt;
	reg bias_out_nxt;
	reg active_out_nxt;

	always @* begin
		fd_out_nxt = fd_tolerance_enable;
		swk_out_nxt = selective_wake_enable;
		pnok_out_nxt = pn_config_valid;
		tx_out_nxt = tx_allowed;
		rx_out_nxt = rx_path_on;
		bias_out_nxt = rx_path_on;
		active_out_nxt = is_active;
	end

	// Each output leaves its own flip-flop, so pins never see decode glitches
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fd_tolerance_enable_o <= 1'b0;
		end else begin
			fd_tolerance_enable_o <= fd_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			selective_wake_enable_o <= 1'b0;
		end else begin
			selective_wake_enable_o <= swk_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pn_config_valid_o <= 1'b0;
		end else begin
			pn_config_valid_o <= pnok_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tx_enable_o <= 1'b0;
		end else begin
			tx_enable_o <= tx_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rx_enable_o <= 1'b0;
		end else begin
			rx_enable_o <= rx_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bias_enable_o <= 1'b0;
		end else begin
			bias_enable_o <= bias_out_nxt;
		end
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			active_mode_o <= 1'b0;
		end else begin
			active_mode_o <= active_out_nxt;
		end
	end
endmodule // cxr_regs
`default_nettype wire

// ==== core/cxr_sync2.v ====
// Two-flop synchroniser bank for asynchronous status inputs
`timescale 1ns/1ps
`default_nettype none
module cxr_sync2 #(
	parameter W = 8
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Data
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule // cxr_sync2
`default_nettype wire

// ==== verification/cxr_host.sv ====
// Host model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module cxr_host (
	// Clock
	input wire logic clock_i,
	// Register port
	output logic [6:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 7'h00;
		wr_o = 1'h0;
		wdata_o = 8'h00;
	end
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock_i) #1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'h1;
		@(posedge clock_i) #1;
		wr_o = 1'h0;
		// Stale data must not look valid
		wdata_o = ~d;
	endtask
	task rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clock_i) #1;
		addr_o = a;
		@(posedge clock_i) #1;
		d = rdata_i;
	endtask
endmodule // cxr_host
`default_nettype wire

// ==== verification/cxr_regs_bench.sv ====
// Bench for the transceiver register pair
`timescale 1ns/1ps
`default_nettype none
`include "cxr_consts.vh"
module cxr_regs_bench;
	logic clock_i, rst_i, reg_wr_i, normal_mode_i, txd_i, supply_low_i, bat_low_i, ok;
	logic osc_locked_i, bus_silent_i, tx_timeout_i, frame_detect_error_i, bias_enable_o;
	logic fd_tolerance_enable_o, selective_wake_enable_o, pn_config_valid_o;
	logic tx_enable_o, rx_enable_o, active_mode_o;
	logic [6:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, rv;
	logic [1:0] md;
	int failures, checks_done, cyc;
	cxr_host u_cxr_host (.clock_i(clock_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));
	cxr_regs u_cxr_regs (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.normal_mode_i(normal_mode_i), .txd_i(txd_i), .supply_low_i(supply_low_i),
		.bat_low_i(bat_low_i), .osc_locked_i(osc_locked_i), .bus_silent_i(bus_silent_i),
		.tx_timeout_i(tx_timeout_i), .frame_detect_error_i(frame_detect_error_i),
		.fd_tolerance_enable_o(fd_tolerance_enable_o),
		.selective_wake_enable_o(selective_wake_enable_o),
		.pn_config_valid_o(pn_config_valid_o), .tx_enable_o(tx_enable_o),
		.rx_enable_o(rx_enable_o), .bias_enable_o(bias_enable_o),
		.active_mode_o(active_mode_o));
	initial begin
		clock_i = 1'h0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task wt();
		repeat (6) @(posedge clock_i);
		#1;
	endtask
	task ctl(input logic [7:0] d);
		u_cxr_host.wr(`CXR_CTRL_ADDR, d);
		{ok, md} = {d[5], d[1:0]};
		wt();
	endtask
	task cfg(input logic [6:0] a);
		u_cxr_host.wr(a, 8'h5a);
		ok = 1'h0;
		wt();
	endtask
	task rdc(input logic [6:0] a, input logic [7:0] e);
		u_cxr_host.rd(a, rv);
		chk(rv, e);
	endtask
	task chs(input logic a);
		rdc(`CXR_STAT_ADDR, {a, frame_detect_error_i | !ok, ok, osc_locked_i, bus_silent_i,
			1'h0, supply_low_i && md == `CXR_MODE_ACT_UV, tx_timeout_i});
	endtask
	task cko(input logic [6:0] e);
		chk({1'h0, fd_tolerance_enable_o, selective_wake_enable_o, pn_config_valid_o,
			active_mode_o, tx_enable_o, rx_enable_o, bias_enable_o}, {1'h0, e});
	endtask
	task t_ctrl();
		normal_mode_i = 1'h1;
		ctl(8'hff);
		rdc(`CXR_CTRL_ADDR, 8'h73);
		cko(7'h73);
		u_cxr_host.wr(`CXR_STAT_ADDR, 8'h00);
		rdc(`CXR_CTRL_ADDR, 8'h73);
		cfg(`CXR_PN_CFG_LO);
		cko(7'h63);
		chs(1'h0);
		ctl(8'h30);
		cfg(`CXR_PN_CFG_HI);
		cko(7'h20);
	endtask
	task t_act();
		ctl(8'h01);
		cko(7'h0f);
		chs(1'h1);
		supply_low_i = 1'h1;
		wt();
		cko(7'h00);
		chs(1'h0);
		ctl(8'h02);
		chs(1'h1);
		bat_low_i = 1'h1;
		wt();
		cko(7'h00);
		{bat_low_i, supply_low_i} = 2'h0;
		ctl(8'h00);
		txd_i = 1'h0;
		ctl(8'h01);
		cko(7'h03);
		txd_i = 1'h1;
		wt();
		cko(7'h0f);
		{osc_locked_i, bus_silent_i, frame_detect_error_i, tx_timeout_i} = 4'hf;
		wt();
		cko(7'h0b);
		chs(1'h1);
	endtask
	initial begin
		{rst_i, normal_mode_i, txd_i, supply_low_i, bat_low_i} = 5'h14;
		{osc_locked_i, bus_silent_i, tx_timeout_i, frame_detect_error_i, ok, md} = 7'h00;
		repeat (10) @(posedge clock_i);
		#1;
		rst_i = 1'h0;
		wt();
		rdc(`CXR_CTRL_ADDR, `CXR_CTRL_RST);
		chs(1'h0);
		t_ctrl();
		t_act();
		report_and_stop();
	end
	task report_and_stop();
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
endmodule // cxr_regs_bench
bind cxr_regs cxr_regs_props u_cxr_regs_props (.clock_i(clock_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .fd_tolerance_enable_o(fd_tolerance_enable_o),
	.pn_config_valid_o(pn_config_valid_o), .tx_enable_o(tx_enable_o),
	.rx_enable_o(rx_enable_o), .active_mode_o(active_mode_o));
`default_nettype wire

// ==== verification/cxr_regs_props.sv ====
// Port assertions for the register pair
`timescale 1ns/1ps
`default_nettype none
`include "cxr_consts.vh"
module cxr_regs_props (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port
	input wire logic [6:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Transceiver control
	input wire logic fd_tolerance_enable_o,
	input wire logic pn_config_valid_o,
	input wire logic tx_enable_o,
	input wire logic rx_enable_o,
	input wire logic active_mode_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	wire cw = reg_wr_i && reg_addr_i == `CXR_CTRL_ADDR;
	wire pw = reg_wr_i && reg_addr_i >= `CXR_PN_CFG_LO && reg_addr_i <= `CXR_PN_CFG_HI;
	a_fd_ctl: assert property (cw |-> ##2 fd_tolerance_enable_o == $past(reg_wdata_i[6],2))
		else $error("fd enable wrong");
	a_ok_ctl: assert property (cw |-> ##2 pn_config_valid_o == $past(reg_wdata_i[5],2))
		else $error("config valid wrong");
	a_cfg_clear: assert property (pw |-> ##2 !pn_config_valid_o)
		else $error("config valid not cleared");
	a_rsvd_zero: assert property ($past(reg_addr_i) == `CXR_CTRL_ADDR |->
		reg_rdata_o[7] == 1'h0 && reg_rdata_o[3:2] == 2'h0) else $error("reserved bit set");
	a_stat_ok: assert property ($past(reg_addr_i) == `CXR_STAT_ADDR |->
		reg_rdata_o[5] == pn_config_valid_o) else $error("config status wrong");
	a_stat_err: assert property ($past(reg_addr_i) == `CXR_STAT_ADDR && !pn_config_valid_o
		|-> reg_rdata_o[6]) else $error("error status wrong");
	a_listen_quiet: assert property (rx_enable_o && !active_mode_o |-> !tx_enable_o)
		else $error("transmit in listen");
	a_tx_active: assert property (tx_enable_o |-> active_mode_o && rx_enable_o)
		else $error("transmit while inactive");
	c_ctrl_wr: cover property (cw);
	c_cfg_wr: cover property (pw);
	c_active: cover property ($rose(active_mode_o));
endmodule // cxr_regs_props
`default_nettype wire
